// ### core/tone_supervisor_pkg.sv
// Purpose: shared constants, field layouts and helpers for the tone response supervisor
// Assumes: 25 MHz system clock, 8-bit register port
// Notes: all durations are kept in microseconds and converted to timebase ticks
package tone_supervisor_pkg;

    // ****************************************************************
    // clock and timebase
    // ****************************************************************
    localparam int unsigned CLOCK_PERIOD_NS = 40;
    localparam int unsigned TICK_US = 125;                        // timebase resolution
    localparam int unsigned TICK_CYCLES = (TICK_US * 1000) / CLOCK_PERIOD_NS;
    localparam int unsigned TICK_CNT_W = 12;
    localparam int unsigned TIME_W = 13;                          // width of the duration counters, counted in ticks

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] ADDR_PHASE_CFG = 8'h1c;
    localparam logic [7:0] ADDR_CONT_TIMERS = 8'h1d;
    localparam logic [7:0] ADDR_STATUS = 8'h1e;
    localparam logic [7:0] PHASE_CFG_RESET = 8'h43;
    localparam logic [7:0] CONT_TIMERS_RESET = 8'h00;

    // status bit positions
    localparam int unsigned ST_EVAL_BIT = 0;
    localparam int unsigned ST_FOUND_BIT = 1;
    localparam int unsigned ST_COEFF_BIT = 2;
    localparam int unsigned ST_BYPASS_BIT = 3;

    // phase shift detector configuration, msb first
    typedef struct packed {
        logic long_interval_eval_en;
        logic [1:0] evaluation_period_sel;
        logic [1:0] interruption_min_sel;
        logic [2:0] interruption_max_sel;
    } phase_cfg_t;

    // continuity tone timers, msb first
    typedef struct packed {
        logic [3:0] continuity_reset_guard;
        logic [3:0] continuity_bypass_guard;
    } cont_cfg_t;

    // ****************************************************************
    // durations in microseconds
    // ****************************************************************
    localparam int unsigned EVAL_PERIOD_US [4] = '{749000, 833000, 916000, 999000};
    localparam int unsigned INTR_MIN_US [4] = '{1125, 2250, 3375, 4500};
    localparam int unsigned INTR_MAX_US [8] = '{27000, 28000, 29000, 30000, 32000, 33000, 34000, 35000};
    localparam int unsigned LONG_INTERVAL_US = 30000;
    localparam int unsigned GUARD_STEP_US = 8000;

    localparam logic [TIME_W-1:0] TIME_SAT = {TIME_W{1'b1}};

    // converts microseconds to whole ticks, never below one
    function automatic logic [TIME_W-1:0] us_to_ticks(input int unsigned us);
        int unsigned t;
        t = us / TICK_US;
        if (t == 0) begin
            t = 1;
        end
        return TIME_W'(t);
    endfunction

    // saturating tick counter step
    function automatic logic [TIME_W-1:0] sat_inc(input logic [TIME_W-1:0] v);
        return (v == TIME_SAT) ? v : v + TIME_W'(1);
    endfunction

    // guard field to ticks: field times the 8 ms step
    function automatic logic [TIME_W-1:0] guard_ticks(input logic [3:0] g);
        return TIME_W'(TIME_W'(g) * us_to_ticks(GUARD_STEP_US));
    endfunction

endpackage

// ### core/tone_response_supervisor.sv
// Purpose: supervises answer tone phase reversals and continuity tone presence for an echo canceller
// Assumes: tone and reversal indications are synchronous to clock
// Notes: reset and bypass requests are levels held while their condition stands
//
// Contract
// R1 - phase reversals spaced more than 30 ms apart count only when the long-interval enable bit is set.
// R2 - the two-bit evaluation field picks 749, 833, 916 or 999 ms, and evaluation ends if no shift falls in it.
// R3 - a tone interruption counts as a shift only if at least 1.125, 2.250, 3.375 or 4.500 ms long.
// R4 - a tone interruption counts as a shift only if at most 27, 28, 29, 30, 32, 33, 34 or 35 ms long.
// R5 - a continuity timer register of zero disables continuity tone handling completely.
// R6 - coefficient reset is requested after the continuity tone stands for reset field times 8 ms, never for zero.
// R7 - bypass is requested after the continuity tone stands for bypass field times 8 ms, never for zero.
// R8 - the phase detector configuration resets to 0x43.
// R9 - the continuity presence timer restarts from zero whenever the tone drops.
// R10 - every duration is measured with a 125 us tick made from the system clock.
`timescale 1ns/1ns
module tone_response_supervisor #(
    // timebase length in clock cycles, 125 us at the documented clock
    parameter int unsigned TICK_LEN = tone_supervisor_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [tone_supervisor_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tone_supervisor_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [tone_supervisor_pkg::DATA_W-1:0] reg_rdata,
    // detector indications
    input wire logic answer_tone_present,
    input wire logic phase_reversal,
    input wire logic continuity_tone_present,
    // requests
    output logic phase_shift_pulse,
    output logic answer_phase_found,
    output logic coeff_reset_req,
    output logic bypass_req
);
    import tone_supervisor_pkg::*;

    typedef enum logic [1:0] {EV_IDLE, EV_RUN, EV_FOUND} eval_state_t;

    phase_cfg_t phase_cfg;
    cont_cfg_t cont_cfg;
    eval_state_t eval_state;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic tick;
    logic tone_q;
    logic [TIME_W-1:0] gap_cnt;
    logic [TIME_W-1:0] eval_cnt;
    logic [TIME_W-1:0] space_cnt;
    logic [TIME_W-1:0] cont_cnt;
    logic tone_rise;
    logic gap_in_window;
    logic shift_event;
    logic shift_counted;
    logic eval_expired;
    logic cont_enabled;
    logic [DATA_W-1:0] status;

    // refuse a timebase that the tick counter cannot hold
    if (TICK_LEN < 1 || TICK_LEN > (1 << TICK_CNT_W)) begin : tick_len_check
        $error("tick length out of range");
    end

    // ****************************************************************
    // register port
    // ****************************************************************

    // configuration writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_cfg <= phase_cfg_t'(PHASE_CFG_RESET); // R8
            cont_cfg <= cont_cfg_t'(CONT_TIMERS_RESET);
        end else if (reg_write) begin
            if (reg_addr == ADDR_PHASE_CFG) begin
                phase_cfg <= phase_cfg_t'(reg_wdata);
            end
            if (reg_addr == ADDR_CONT_TIMERS) begin
                cont_cfg <= cont_cfg_t'(reg_wdata);
            end
        end
    end

    // live status word
    always_comb begin
        status = '0;
        status[ST_EVAL_BIT] = (eval_state == EV_RUN);
        status[ST_FOUND_BIT] = answer_phase_found;
        status[ST_COEFF_BIT] = coeff_reset_req;
        status[ST_BYPASS_BIT] = bypass_req;
    end

    // read data stands one cycle after the strobe, zero elsewhere
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_PHASE_CFG: reg_rdata <= phase_cfg;
                ADDR_CONT_TIMERS: reg_rdata <= cont_cfg;
                ADDR_STATUS: reg_rdata <= status;
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ****************************************************************
    // timebase
    // ****************************************************************

    // one-cycle tick every TICK_LEN clocks, 125 us by default
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == TICK_CNT_W'(TICK_LEN - 1)) begin
            tick_cnt <= '0; // R10
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + TICK_CNT_W'(1);
            tick <= 1'b0;
        end
    end

    // ****************************************************************
    // answer tone interruption and phase shift evaluation
    // ****************************************************************

    assign tone_rise = answer_tone_present && !tone_q;
    assign gap_in_window = tone_rise
        && (gap_cnt >= us_to_ticks(INTR_MIN_US[phase_cfg.interruption_min_sel])) // R3
        && (gap_cnt <= us_to_ticks(INTR_MAX_US[phase_cfg.interruption_max_sel])); // R4
    assign shift_event = (eval_state == EV_RUN) && (phase_reversal || gap_in_window);
    assign shift_counted = shift_event
        && (phase_cfg.long_interval_eval_en || space_cnt <= us_to_ticks(LONG_INTERVAL_US)); // R1
    assign eval_expired = eval_cnt >= us_to_ticks(EVAL_PERIOD_US[phase_cfg.evaluation_period_sel]); // R2

    // tone edge memory and length of the current interruption
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tone_q <= 1'b0;
            gap_cnt <= '0;
        end else begin
            tone_q <= answer_tone_present;
            if (answer_tone_present) begin
                gap_cnt <= '0;
            end else if (tick) begin
                gap_cnt <= sat_inc(gap_cnt); // R10
            end
        end
    end

    // evaluation time and spacing since the last shift
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eval_cnt <= '0;
            space_cnt <= '0;
        end else if (eval_state != EV_RUN) begin
            eval_cnt <= '0;
            space_cnt <= '0;
        end else begin
            if (tick) begin
                eval_cnt <= sat_inc(eval_cnt);
            end
            if (shift_event) begin
                space_cnt <= '0; // R1
            end else if (tick) begin
                space_cnt <= sat_inc(space_cnt);
            end
        end
    end

    // evaluation sequence: start on tone onset, end on shift or timeout
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eval_state <= EV_IDLE;
        end else begin
            case (eval_state)
                EV_IDLE: begin
                    if (tone_rise) begin
                        eval_state <= EV_RUN;
                    end
                end
                EV_RUN: begin
                    if (shift_counted) begin
                        eval_state <= EV_FOUND;
                    end else if (eval_expired) begin
                        eval_state <= EV_IDLE; // R2
                    end
                end
                EV_FOUND: begin
                    if (gap_cnt > us_to_ticks(INTR_MAX_US[phase_cfg.interruption_max_sel])) begin
                        eval_state <= EV_IDLE;
                    end
                end
                default: eval_state <= EV_IDLE;
            endcase
        end
    end

    // phase shift outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_shift_pulse <= 1'b0;
            answer_phase_found <= 1'b0;
        end else begin
            phase_shift_pulse <= shift_counted;
            answer_phase_found <= (eval_state == EV_RUN && shift_counted)
                || (eval_state == EV_FOUND
                    && gap_cnt <= us_to_ticks(INTR_MAX_US[phase_cfg.interruption_max_sel]));
        end
    end

    // ****************************************************************
    // continuity tone protection timers
    // ****************************************************************

    assign cont_enabled = (cont_cfg != cont_cfg_t'(CONT_TIMERS_RESET)); // R5

    // presence time of the continuity tone
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cont_cnt <= '0;
        end else if (!continuity_tone_present || !cont_enabled) begin
            cont_cnt <= '0; // R9
        end else if (tick) begin
            cont_cnt <= sat_inc(cont_cnt);
        end
    end

    // reset and bypass requests once the guard time is reached
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            coeff_reset_req <= 1'b0;
            bypass_req <= 1'b0;
        end else begin
            coeff_reset_req <= cont_enabled && continuity_tone_present
                && (cont_cfg.continuity_reset_guard != 4'h0)
                && (cont_cnt >= guard_ticks(cont_cfg.continuity_reset_guard)); // R6
            bypass_req <= cont_enabled && continuity_tone_present
                && (cont_cfg.continuity_bypass_guard != 4'h0)
                && (cont_cnt >= guard_ticks(cont_cfg.continuity_bypass_guard)); // R7
        end
    end

endmodule

// ### sim/tone_supervisor_props.sv
// Purpose: port-level checks for the tone response supervisor
// Assumes: one clock domain, async active-low reset
// Notes: guard checks use a run counter of continuity tone cycles
`timescale 1ns/1ns
module tone_supervisor_props #(parameter int unsigned TICK_LEN = tone_supervisor_pkg::TICK_CYCLES) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [tone_supervisor_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tone_supervisor_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [tone_supervisor_pkg::DATA_W-1:0] reg_rdata,
    // detector indications
    input wire logic answer_tone_present,
    input wire logic phase_reversal,
    input wire logic continuity_tone_present,
    // requests
    input wire logic phase_shift_pulse,
    input wire logic answer_phase_found,
    input wire logic coeff_reset_req,
    input wire logic bypass_req
);
    import tone_supervisor_pkg::*;
    // ****************************************************************
    // helper logic and assertions
    // ****************************************************************
    localparam int unsigned GUARD_MIN_CYCLES = 63 * TICK_LEN + 1; // one guard step, first tick may come early
    logic [19:0] tone_run;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // counts cycles of unbroken continuity tone, saturating
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tone_run <= 20'h00000;
        end else if (!continuity_tone_present) begin
            tone_run <= 20'h00000;
        end else if (tone_run != 20'hfffff) begin
            tone_run <= tone_run + 20'h00001;
        end
    end
    sequence pulse_then_low;
        phase_shift_pulse ##1 !phase_shift_pulse;
    endsequence
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    pulse_single_a: assert property (phase_shift_pulse |-> pulse_then_low)
        else $error("phase shift pulse longer than one cycle");
    pulse_found_a: assert property (phase_shift_pulse |-> answer_phase_found)
        else $error("pulse without found flag");
    found_rise_a: assert property ($rose(answer_phase_found) |-> phase_shift_pulse)
        else $error("found flag rose without a counted shift");
    pulse_cause_a: assert property (phase_shift_pulse |-> $past(phase_reversal) || $past(answer_tone_present))
        else $error("pulse without reversal or returning tone");
    reset_drop_a: assert property (!continuity_tone_present |=> !coeff_reset_req)
        else $error("coefficient reset held after tone dropped");
    bypass_drop_a: assert property (!continuity_tone_present |=> !bypass_req)
        else $error("bypass held after tone dropped");
    reset_guard_a: assert property ($rose(coeff_reset_req) |-> tone_run >= GUARD_MIN_CYCLES)
        else $error("coefficient reset before protection time");
    bypass_guard_a: assert property ($rose(bypass_req) |-> tone_run >= GUARD_MIN_CYCLES)
        else $error("bypass before protection time");
endmodule

bind tone_response_supervisor tone_supervisor_props #(.TICK_LEN(TICK_LEN)) props (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .answer_tone_present(answer_tone_present), .phase_reversal(phase_reversal),
    .continuity_tone_present(continuity_tone_present), .phase_shift_pulse(phase_shift_pulse),
    .answer_phase_found(answer_phase_found), .coeff_reset_req(coeff_reset_req), .bypass_req(bypass_req));

// ### sim/tone_response_supervisor_tb.sv
// Purpose: self-checking bench for the tone response supervisor
// Assumes: 25 MHz clock, timebase shortened to TL cycles per tick
// Notes: all windows and guards are counted in ticks, so they scale with the short tick
`timescale 1ns/1ns
module tone_response_supervisor_tb;
    import tone_supervisor_pkg::*;
    // ****************************************************************
    // signals, tasks and sequence
    // ****************************************************************
    localparam int unsigned TL = 4; // clocks per tick in this run
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} row_t;
    localparam row_t ROWS [5] = '{'{8'h1c, 8'ha5, 8'ha5}, '{8'h1d, 8'h3c, 8'h3c}, '{8'h1e, 8'hff, 8'h00},
        '{8'h40, 8'h77, 8'h00}, '{8'h1d, 8'h00, 8'h00}};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic answer_tone_present = 1'b0;
    logic phase_reversal = 1'b0;
    logic continuity_tone_present = 1'b0;
    logic [7:0] reg_rdata;
    logic phase_shift_pulse, answer_phase_found, coeff_reset_req, bypass_req;
    int checked = 0;
    int miscompares = 0;
    tone_response_supervisor #(.TICK_LEN(TL)) dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .answer_tone_present(answer_tone_present), .phase_reversal(phase_reversal),
        .continuity_tone_present(continuity_tone_present), .phase_shift_pulse(phase_shift_pulse),
        .answer_phase_found(answer_phase_found), .coeff_reset_req(coeff_reset_req), .bypass_req(bypass_req));
    // free-running clock
    always #20 clock = ~clock;
    // compares one value and counts it
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    // watches four cycles for a phase shift pulse
    task automatic pulse_seen(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            @(negedge clock);
            seen = seen | phase_shift_pulse;
        end
        @(posedge clock);
        check("phase_shift_pulse", {7'h00, seen}, {7'h00, exp});
    endtask
    // lets a number of cycles pass, then compares both continuity requests
    task automatic cont_hold(input int cycles, input logic exp_c, input logic exp_b);
        repeat (cycles) @(posedge clock);
        @(negedge clock);
        check("coeff_reset_req", {7'h00, coeff_reset_req}, {7'h00, exp_c});
        check("bypass_req", {7'h00, bypass_req}, {7'h00, exp_b});
        @(posedge clock);
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] v;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(ADDR_PHASE_CFG, v);
        check("phase cfg", v, 8'h43);
        rd(ADDR_CONT_TIMERS, v);
        check("continuity timers", v, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd(ROWS[i].addr, v);
            check("register", v, ROWS[i].rexp);
        end
        $display("test register table done");
        continuity_tone_present <= 1'b1;
        repeat (70 * TL) @(posedge clock);
        check("coeff_reset_req", {7'h00, coeff_reset_req}, 8'h00);
        check("bypass_req", {7'h00, bypass_req}, 8'h00);
        continuity_tone_present <= 1'b0;
        phase_reversal <= 1'b1;
        @(posedge clock);
        phase_reversal <= 1'b0;
        pulse_seen(1'b0);
        $display("test disabled and idle done");
        do_reset();
        rd(ADDR_PHASE_CFG, v);
        check("phase cfg after reset", v, 8'h43);
        answer_tone_present <= 1'b1;
        repeat (3) @(posedge clock);
        phase_reversal <= 1'b1;
        @(posedge clock);
        phase_reversal <= 1'b0;
        pulse_seen(1'b1);
        rd(ADDR_STATUS, v);
        check("status found", v & 8'h02, 8'h02);
        answer_tone_present <= 1'b0;
        do_reset();
        check("answer_phase_found", {7'h00, answer_phase_found}, 8'h00);
        $display("test reversal in evaluation done");
        answer_tone_present <= 1'b1;
        repeat (5) @(posedge clock);
        answer_tone_present <= 1'b0;
        repeat (5 * TL) @(posedge clock);
        answer_tone_present <= 1'b1;
        pulse_seen(1'b0);
        answer_tone_present <= 1'b0;
        repeat (11 * TL) @(posedge clock);
        answer_tone_present <= 1'b1;
        pulse_seen(1'b1);
        $display("test interruption window done");
        wr(ADDR_CONT_TIMERS, 8'h12);
        continuity_tone_present <= 1'b1;
        cont_hold(63 * TL, 1'b0, 1'b0);
        cont_hold(2 * TL, 1'b1, 1'b0);
        cont_hold(64 * TL, 1'b1, 1'b1);
        continuity_tone_present <= 1'b0;
        cont_hold(1, 1'b0, 1'b0);
        wr(ADDR_CONT_TIMERS, 8'h10);
        continuity_tone_present <= 1'b1;
        cont_hold(40 * TL, 1'b0, 1'b0);
        continuity_tone_present <= 1'b0;
        @(posedge clock);
        continuity_tone_present <= 1'b1;
        cont_hold(40 * TL, 1'b0, 1'b0);
        cont_hold(25 * TL, 1'b1, 1'b0);
        continuity_tone_present <= 1'b0;
        $display("test continuity guards done");
        do_reset();
        answer_tone_present <= 1'b1;
        repeat (250 * TL) @(posedge clock);
        phase_reversal <= 1'b1;
        @(posedge clock);
        phase_reversal <= 1'b0;
        pulse_seen(1'b0);
        phase_reversal <= 1'b1;
        @(posedge clock);
        phase_reversal <= 1'b0;
        pulse_seen(1'b1);
        $display("test long interval done");
        do_reset();
        answer_tone_present <= 1'b0;
        wr(ADDR_PHASE_CFG, 8'h83);
        answer_tone_present <= 1'b1;
        repeat (5980 * TL) @(posedge clock);
        rd(ADDR_STATUS, v);
        check("status running", v & 8'h01, 8'h01);
        repeat (20 * TL) @(posedge clock);
        rd(ADDR_STATUS, v);
        check("status expired", v & 8'h01, 8'h00);
        phase_reversal <= 1'b1;
        @(posedge clock);
        phase_reversal <= 1'b0;
        pulse_seen(1'b0);
        answer_tone_present <= 1'b0;
        @(posedge clock);
        answer_tone_present <= 1'b1;
        repeat (250 * TL) @(posedge clock);
        phase_reversal <= 1'b1;
        @(posedge clock);
        phase_reversal <= 1'b0;
        pulse_seen(1'b1);
        $display("test evaluation expiry done");
        print_verdict();
    end
endmodule
